// ---- board_irq_pkg.sv ----
// shared constants and carrier types for the board support register bank
package board_irq_pkg;

    // ----------------------------------------
    // register offsets (byte addresses in io space)
    // ----------------------------------------
    localparam logic [6:0] OFF_FORCE    = 7'h00;
    localparam logic [6:0] OFF_VECTOR   = 7'h02;
    localparam logic [6:0] OFF_STATUS   = 7'h04;
    localparam logic [6:0] OFF_LOCATION = 7'h06;
    localparam logic [6:0] OFF_REVISION = 7'h0a;
    localparam logic [6:0] OFF_CH0_CTRL = 7'h14;
    localparam logic [6:0] OFF_CH0_STAT = 7'h16;
    localparam logic [6:0] OFF_CH1_CTRL = 7'h28;
    localparam logic [6:0] OFF_CH1_STAT = 7'h2a;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_PENDING     = 0;
    localparam int BIT_CH0_RAW     = 4;
    localparam int BIT_CH1_RAW     = 6;
    localparam int BIT_HOST_LOCK   = 8;
    localparam int BIT_PROTO_LOCK  = 9;
    localparam int BIT_TAG_LOCK    = 10;
    localparam int BIT_RESET_LOW   = 12;
    localparam int BIT_SELFTEST_LO = 13;
    localparam int BIT_LOW_POWER   = 14;
    localparam int BIT_IRQ_ENABLE  = 15;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [7:0]  RST_VECTOR = 8'hff;

    // ----------------------------------------
    // identification space
    // ----------------------------------------
    localparam logic [7:0] ID_MAKER      = 8'h5a; // arbitrary value
    localparam logic [7:0] ID_MODEL      = 8'h3c; // arbitrary value
    localparam logic [7:0] ID_EXTRA_CNT  = 8'h0c;
    localparam logic [4:0] ID_ADDR_REV   = 5'h0d;
    localparam logic [4:0] ID_ADDR_EXTRA = 5'h15;

    // ----------------------------------------
    // carrier types
    // ----------------------------------------
    typedef struct packed {
        logic        ioSel;
        logic        idSel;
        logic        write;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic resetLow;
        logic selftestOnResetLow;
        logic lowPowerPermit;
    } chan_drive_s;

endpackage : board_irq_pkg

// ---- board_irq_status_control.sv ----
// board level interrupt, lock status and channel control register bank
// Functional notes
// - pending bit set by force or masked channel irq; clears when source goes
// - raw channel irqs shown at status bits 4 and 6 before masking
// - active-low protocol chip irq outputs inverted to active-high status
// - status bit 8 shows host clock manager lock
// - status bit 9 shows protocol clocks locked and generated
// - status bit 10 shows stable external time-tag clock locked
// - location register fully read/write, loaded by driver with switch and slot
// - revision register: minor in low byte, major in high byte
// - id space byte 0d returns major revision
// - channel control bit 12 drives protocol master clear directly
// - channel control bit 13 drives self-test-on-reset request
// - channel control bit 14 drives low power permit
// - channel irq reaches host line only while control bit 15 set
// - channel status bit 0 mirrors unmasked channel irq
// - combined irq drives host request line zero, auto-vectored
// - after power-on no pending request and all irqs disabled
// - enables act after holding latches so polling always works
// - identification prom of at least 32 bytes readable in id space
// - prom bytes at odd addresses: marker, maker, model, major revision, zero driver id, count
// - hardware reset clears every register except vector
`timescale 1ns/10ps
`default_nettype none
module board_irq_status_control
    import board_irq_pkg::*;
#(
    parameter logic [7:0] REV_MAJOR = 8'h04,
    parameter logic [7:0] REV_MINOR = 8'h01,
    parameter int         CHANNELS  = 2
) (
    input  wire logic                clk,
    input  wire logic                protocol_reset_input_low,
    input  wire host_req_s           hostReq,
    output logic                     hostAck,
    output logic [15:0]              hostRdata,
    input  wire logic [CHANNELS-1:0] chanIrqLow,
    input  wire logic                hostClockLocked,
    input  wire logic                protoClockLocked,
    input  wire logic                tagClockLocked,
    output logic                     hostIrqLow,
    output chan_drive_s              chanDrive0,
    output chan_drive_s              chanDrive1
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (CHANNELS != 2) begin : g_bad_channels
        $error("board_irq_status_control serves exactly two channels");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic        forceIrq;
        logic [7:0]  vector;
        logic [15:0] location;
        logic [15:0] ctrl0;
        logic [15:0] ctrl1;
        logic        ack;
        logic [15:0] rdata;
        logic        irqOut;
    } bank_state_s;

    bank_state_s st;
    bank_state_s next_st;

    logic [CHANNELS-1:0] chanIrqSync;
    logic [2:0]          lockSync;
    logic [CHANNELS-1:0] chanIrq;
    logic [CHANNELS-1:0] chanEnable;
    logic                pending;
    logic [15:0]         statusWord;
    logic [7:0]          idByte;
    logic                accessStart;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    sync_two_flop #(.WIDTH(CHANNELS), .RST_LEVEL({CHANNELS{1'b1}})) u_sync_irq (
        .clk     (clk),
        .protocol_reset_input_low    (protocol_reset_input_low),
        .asyncIn (chanIrqLow),
        .syncOut (chanIrqSync)
    );

    sync_two_flop #(.WIDTH(3)) u_sync_lock (
        .clk     (clk),
        .protocol_reset_input_low    (protocol_reset_input_low),
        .asyncIn ({tagClockLocked, protoClockLocked, hostClockLocked}),
        .syncOut (lockSync)
    );

    // ----------------------------------------
    // interrupt combine
    // ----------------------------------------
    assign chanIrq    = ~chanIrqSync;
    assign chanEnable = {st.ctrl1[BIT_IRQ_ENABLE], st.ctrl0[BIT_IRQ_ENABLE]};
    assign pending    = st.forceIrq | (|(chanIrq & chanEnable));

    always_comb begin
        statusWord                 = '0;
        statusWord[BIT_PENDING]    = pending;
        statusWord[BIT_CH0_RAW]    = chanIrq[0];
        statusWord[BIT_CH1_RAW]    = chanIrq[1];
        statusWord[BIT_HOST_LOCK]  = lockSync[0];
        statusWord[BIT_PROTO_LOCK] = lockSync[1];
        statusWord[BIT_TAG_LOCK]   = lockSync[2];
    end

    // ----------------------------------------
    // identification prom
    // ----------------------------------------
    always_comb begin
        unique case (hostReq.addr[4:0])
            5'h01:        idByte = 8'h49;
            5'h03:        idByte = 8'h50;
            5'h05:        idByte = 8'h41;
            5'h07:        idByte = 8'h48;
            5'h09:        idByte = ID_MAKER;
            5'h0b:        idByte = ID_MODEL;
            ID_ADDR_REV:  idByte = REV_MAJOR;
            ID_ADDR_EXTRA: idByte = ID_EXTRA_CNT;
            default:      idByte = 8'h00;
        endcase
    end

    // ----------------------------------------
    // register access
    // ----------------------------------------
    assign accessStart = (hostReq.ioSel | hostReq.idSel) & ~st.ack;

    always_comb begin
        next_st     = st;
        next_st.ack = accessStart;
        next_st.irqOut = pending;
        if (accessStart && hostReq.idSel) begin
            next_st.rdata = {8'h00, idByte};
        end else if (accessStart && hostReq.write) begin
            unique case (hostReq.addr)
                OFF_FORCE:    next_st.forceIrq = hostReq.wdata[0];
                OFF_VECTOR:   next_st.vector   = hostReq.wdata[7:0];
                OFF_LOCATION: next_st.location = hostReq.wdata;
                OFF_CH0_CTRL: next_st.ctrl0    = {hostReq.wdata[15:12], 12'h000};
                OFF_CH1_CTRL: next_st.ctrl1    = {hostReq.wdata[15:12], 12'h000};
                default:      next_st.forceIrq = st.forceIrq;
            endcase
        end else if (accessStart) begin
            unique case (hostReq.addr)
                OFF_FORCE:    next_st.rdata = {15'h0000, st.forceIrq};
                OFF_VECTOR:   next_st.rdata = {8'h00, st.vector};
                OFF_STATUS:   next_st.rdata = statusWord;
                OFF_LOCATION: next_st.rdata = st.location;
                OFF_REVISION: next_st.rdata = {REV_MAJOR, REV_MINOR};
                OFF_CH0_CTRL: next_st.rdata = st.ctrl0;
                OFF_CH0_STAT: next_st.rdata = {15'h0000, chanIrq[0]};
                OFF_CH1_CTRL: next_st.rdata = st.ctrl1;
                OFF_CH1_STAT: next_st.rdata = {15'h0000, chanIrq[1]};
                default:      next_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge protocol_reset_input_low) begin
        if (!protocol_reset_input_low) begin
            st.forceIrq <= 1'b0;
            st.vector   <= RST_VECTOR;
            st.location <= RST_WORD;
            st.ctrl0    <= RST_WORD;
            st.ctrl1    <= RST_WORD;
            st.ack      <= 1'b0;
            st.rdata    <= RST_WORD;
            st.irqOut   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hostAck    = st.ack;
    assign hostRdata  = st.rdata;
    assign hostIrqLow = ~st.irqOut;

    assign chanDrive0.resetLow           = st.ctrl0[BIT_RESET_LOW];
    assign chanDrive0.selftestOnResetLow = st.ctrl0[BIT_SELFTEST_LO];
    assign chanDrive0.lowPowerPermit     = st.ctrl0[BIT_LOW_POWER];
    assign chanDrive1.resetLow           = st.ctrl1[BIT_RESET_LOW];
    assign chanDrive1.selftestOnResetLow = st.ctrl1[BIT_SELFTEST_LO];
    assign chanDrive1.lowPowerPermit     = st.ctrl1[BIT_LOW_POWER];

endmodule : board_irq_status_control
`default_nettype wire

// ---- board_irq_status_control_sva.sv ----
// assertion checker for the board support register bank
`timescale 1ns/10ps
`default_nettype none
module board_irq_status_control_sva
    import board_irq_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic                clk,
    input wire logic                protocol_reset_input_low,
    input wire host_req_s           hostReq,
    input wire logic                hostAck,
    input wire logic [15:0]         hostRdata,
    input wire logic [CHANNELS-1:0] chanIrqLow,
    input wire logic                hostClockLocked,
    input wire logic                protoClockLocked,
    input wire logic                tagClockLocked,
    input wire logic                hostIrqLow,
    input wire chan_drive_s         chanDrive0,
    input wire chan_drive_s         chanDrive1
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!protocol_reset_input_low);
    sequence rdStat;
        hostReq.ioSel && !hostReq.write && hostReq.addr == OFF_STATUS && !hostAck;
    endsequence
    a_ack_after_take: assert property ((hostReq.ioSel || hostReq.idSel) && !hostAck |=> hostAck)
        else $error("no ack after request");
    a_ack_one_pulse: assert property (hostAck |=> !hostAck)
        else $error("ack too long");
    a_rdata_hold: assert property (!$stable(hostRdata) |-> hostAck)
        else $error("read data moved without ack");
    a_drive0_on_write: assert property (!$stable(chanDrive0) |-> hostAck && $past(hostReq.write))
        else $error("channel 0 drive moved without write");
    a_drive1_on_write: assert property (!$stable(chanDrive1) |-> hostAck && $past(hostReq.write))
        else $error("channel 1 drive moved without write");
    a_stat_lock_bits: assert property (
        $stable({tagClockLocked, protoClockLocked, hostClockLocked})[*5] ##0 rdStat
        |=> hostRdata[10:8] == $past({tagClockLocked, protoClockLocked, hostClockLocked}))
        else $error("lock bits wrong");
    a_stat_raw_irq: assert property ($stable(chanIrqLow)[*5] ##0 rdStat
        |=> {hostRdata[6], hostRdata[4]} == ~$past(chanIrqLow))
        else $error("raw irq bits wrong");
    a_id_high_zero: assert property (hostReq.idSel && !hostReq.write && !hostAck |=> hostRdata[15:8] == 8'h00)
        else $error("id high byte not zero");
    cover property (rdStat);
    cover property ($fell(hostIrqLow));
    cover property (hostReq.idSel && hostAck);
endmodule : board_irq_status_control_sva
bind board_irq_status_control board_irq_status_control_sva #(.CHANNELS(CHANNELS)) u_sva (
    .clk(clk), .protocol_reset_input_low(protocol_reset_input_low), .hostReq(hostReq), .hostAck(hostAck), .hostRdata(hostRdata),
    .chanIrqLow(chanIrqLow), .hostClockLocked(hostClockLocked), .protoClockLocked(protoClockLocked),
    .tagClockLocked(tagClockLocked), .hostIrqLow(hostIrqLow), .chanDrive0(chanDrive0), .chanDrive1(chanDrive1));
`default_nettype wire

// ---- proto_chip_model.sv ----
// protocol chip stand-in: active-low irq, quiet in master clear or self-test
`timescale 1ns/10ps
`default_nettype none
module proto_chip_model
    import board_irq_pkg::*;
(
    input  wire logic        clk,
    input  wire chan_drive_s drive,
    input  wire logic        raise,
    output logic             irqLow
);
    logic [3:0] bist = 4'h0;
    logic       wasOut = 1'b0;
    initial irqLow = 1'b1;
    always @(posedge clk) begin
        wasOut <= drive.resetLow;
        if (drive.resetLow && !wasOut && !drive.selftestOnResetLow) bist <= 4'h8;
        else if (bist != 4'h0) bist <= bist - 4'h1;
        irqLow <= !(drive.resetLow && raise && bist == 4'h0);
    end
endmodule : proto_chip_model
`default_nettype wire

// ---- sync_two_flop.sv ----
// two-flop synchroniser for a vector of levels
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop
    import board_irq_pkg::*;
#(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RST_LEVEL = '0
) (
    input  wire logic             clk,
    input  wire logic             protocol_reset_input_low,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_s;

    sync_state_s st;
    sync_state_s next_st;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_two_flop needs at least one bit");
    end

    always_comb begin
        next_st.stage1 = asyncIn;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk or negedge protocol_reset_input_low) begin
        if (!protocol_reset_input_low) begin
            st <= '{stage1: RST_LEVEL, stage2: RST_LEVEL};
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.stage2;
endmodule : sync_two_flop
`default_nettype wire

// ---- tb_board_irq_status_control.sv ----
// self-checking bench for the board support register bank
`timescale 1ns/10ps
`default_nettype none
module tb_board_irq_status_control
    import board_irq_pkg::*;
;
    logic        clk = 1'b0;
    logic        protocol_reset_input_low = 1'b0;
    host_req_s   hostReq = '0;
    logic        hostAck;
    logic [15:0] hostRdata;
    logic [1:0]  chanIrqLow;
    logic [2:0]  locks = 3'h0;
    logic [1:0]  raise = 2'h0;
    logic        hostIrqLow;
    chan_drive_s chanDrive0;
    chan_drive_s chanDrive1;
    logic [15:0] rd;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    always #2 clk = ~clk;
    board_irq_status_control #(.REV_MAJOR(8'h04), .REV_MINOR(8'h01), .CHANNELS(2)) dut (
        .clk(clk), .protocol_reset_input_low(protocol_reset_input_low), .hostReq(hostReq), .hostAck(hostAck), .hostRdata(hostRdata),
        .chanIrqLow(chanIrqLow), .hostClockLocked(locks[0]), .protoClockLocked(locks[1]),
        .tagClockLocked(locks[2]), .hostIrqLow(hostIrqLow), .chanDrive0(chanDrive0), .chanDrive1(chanDrive1));
    proto_chip_model chip0 (.clk(clk), .drive(chanDrive0), .raise(raise[0]), .irqLow(chanIrqLow[0]));
    proto_chip_model chip1 (.clk(clk), .drive(chanDrive1), .raise(raise[1]), .irqLow(chanIrqLow[1]));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic access(input logic id, input logic wr, input logic [6:0] addr, input logic [15:0] wd);
        @(posedge clk);
        #1 hostReq = '{ioSel: !id, idSel: id, write: wr, addr: addr, wdata: wd};
        repeat (8) begin
            @(negedge clk);
            if (hostAck === 1'b1) break;
        end
        rd = hostRdata;
        check("ack", {15'h0, hostAck}, 16'h0001);
        @(posedge clk);
        #1 hostReq = '0;
    endtask : access
    task automatic rdchk(input logic id, input logic [6:0] addr, input logic [15:0] exp, input string what);
        access(id, 1'b0, addr, 16'h0000);
        check(what, rd, exp);
    endtask : rdchk
    task automatic poll(input logic [6:0] addr, input int b, input logic v);
        repeat (20) begin
            access(1'b0, 1'b0, addr, 16'h0000);
            if (rd[b] === v) break;
        end
    endtask : poll
    task automatic wait_irq(input logic v);
        repeat (12) begin
            @(negedge clk);
            if (hostIrqLow === v) break;
        end
        check("irq line", {15'h0, hostIrqLow}, {15'h0, v});
    endtask : wait_irq
    task automatic t_reset;
        check("irq idle", {15'h0, hostIrqLow}, 16'h0001);
        check("drive0", {13'h0, chanDrive0}, 16'h0000);
        rdchk(0, OFF_CH0_CTRL, RST_WORD, "ctrl0");
        rdchk(0, OFF_LOCATION, RST_WORD, "location");
        rdchk(0, OFF_VECTOR, {8'h00, RST_VECTOR}, "vector");
        rdchk(0, OFF_REVISION, 16'h0401, "revision");
        rdchk(1, {2'b00, ID_ADDR_REV}, 16'h0004, "id rev");
        rdchk(1, 7'h01, 16'h0049, "id marker");
        rdchk(1, 7'h0b, {8'h00, ID_MODEL}, "id model");
        rdchk(1, {2'b00, ID_ADDR_EXTRA}, {8'h00, ID_EXTRA_CNT}, "id extra");
        rdchk(0, 7'h30, 16'h0000, "unmapped");
    endtask : t_reset
    task automatic t_regs;
        access(0, 1, OFF_LOCATION, 16'h07fa);
        rdchk(0, OFF_LOCATION, 16'h07fa, "location");
        access(0, 1, OFF_REVISION, 16'hffff);
        rdchk(0, OFF_REVISION, 16'h0401, "revision ro");
        access(0, 1, OFF_CH0_CTRL, 16'hffff);
        check("drive0", {13'h0, chanDrive0}, 16'h0007);
        rdchk(0, OFF_CH0_CTRL, 16'hf000, "ctrl0");
        access(0, 1, OFF_CH1_CTRL, 16'h5000);
        check("drive1", {13'h0, chanDrive1}, 16'h0005);
    endtask : t_regs
    task automatic t_irq;
        for (int ch = 0; ch < 2; ch++) begin
            access(0, 1, ch ? OFF_CH1_CTRL : OFF_CH0_CTRL, 16'h1000);
            raise[ch] = 1'b1;
            poll(OFF_STATUS, ch ? 6 : 4, 1'b1);
            check("status masked", rd, ch ? 16'h0040 : 16'h0010);
            rdchk(0, ch ? OFF_CH1_STAT : OFF_CH0_STAT, 16'h0001, "chan stat");
            check("irq masked", {15'h0, hostIrqLow}, 16'h0001);
            access(0, 1, ch ? OFF_CH1_CTRL : OFF_CH0_CTRL, 16'h9000);
            wait_irq(1'b0);
            rdchk(0, OFF_STATUS, ch ? 16'h0041 : 16'h0011, "pending");
            raise[ch] = 1'b0;
            wait_irq(1'b1);
            poll(ch ? OFF_CH1_STAT : OFF_CH0_STAT, 0, 1'b0);
            check("chan stat clr", rd, 16'h0000);
        end
        access(0, 1, OFF_FORCE, 16'h0001);
        wait_irq(1'b0);
        access(0, 1, OFF_FORCE, 16'h0000);
        wait_irq(1'b1);
    endtask : t_irq
    task automatic t_lock;
        @(posedge clk);
        #1 locks = 3'b101;
        poll(OFF_STATUS, 8, 1'b1);
        rdchk(0, OFF_STATUS, 16'h0500, "locks a");
        locks = 3'b010;
        poll(OFF_STATUS, 9, 1'b1);
        access(0, 1, OFF_STATUS, 16'hffff);
        rdchk(0, OFF_STATUS, 16'h0200, "locks b");
    endtask : t_lock
    task automatic t_rerun;
        access(0, 1, OFF_VECTOR, 16'h1233);
        rdchk(0, OFF_VECTOR, 16'h0033, "vector rw");
        access(0, 1, OFF_FORCE, 16'h0001);
        wait_irq(1'b0);
        @(posedge clk);
        #1 protocol_reset_input_low = 1'b0;
        repeat (4) @(posedge clk);
        #1 protocol_reset_input_low = 1'b1;
        check("irq rerun", {15'h0, hostIrqLow}, 16'h0001);
        check("drive1 rerun", {13'h0, chanDrive1}, 16'h0000);
        rdchk(0, OFF_FORCE, RST_WORD, "force rerun");
        rdchk(0, OFF_LOCATION, RST_WORD, "location rerun");
        rdchk(0, OFF_CH1_CTRL, RST_WORD, "ctrl1 rerun");
        rdchk(0, OFF_VECTOR, {8'h00, RST_VECTOR}, "vector rerun");
    endtask : t_rerun
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(posedge clk);
        #1 protocol_reset_input_low = 1'b1;
        t_reset();
        t_regs();
        t_irq();
        t_lock();
        t_rerun();
        conclude();
    end
    initial begin
        #40000;
        n_mismatch++;
        conclude();
    end
endmodule : tb_board_irq_status_control
`default_nettype wire
